// ---- cscto_params.svh ----
// constants of the clock supervision and test-out block: offsets, fields, codes
// assumes a 32-bit register port with byte addresses in steps of four
`ifndef CSCTO_PARAMS_SVH
`define CSCTO_PARAMS_SVH

// ==========================================================
// register offsets
`define CSC_OFF_TEST 8'h00
`define CSC_OFF_STAT 8'h04
`define CSC_OFF_C1_CTRL 8'h08
`define CSC_OFF_C1_SEED0 8'h0C
`define CSC_OFF_C1_SEED1 8'h10
`define CSC_OFF_C1_WIN 8'h14
`define CSC_OFF_C2_CTRL 8'h18
`define CSC_OFF_C2_SEED0 8'h1C
`define CSC_OFF_C2_SEED1 8'h20
`define CSC_OFF_C2_WIN 8'h24

// ==========================================================
// fields
`define CSC_TEST_EXT 4:0
`define CSC_TEST_TIM 11:8
`define CSC_TEST_PRE 19:16
`define CSC_TEST_EN 24
`define CSC_TEST_MASK 32'h010F_0F1F
`define CSC_ST_OSC 0
`define CSC_ST_ERR1 1
`define CSC_ST_ERR2 2
`define CSC_ST_LIMP 3
`define CSC_ST_BUSY1 8
`define CSC_ST_BUSY2 9
`define CSC_CTRL_KEY 3:0
`define CSC_CTRL_SRC0 11:8
`define CSC_CTRL_SRC1 19:16
`define CSC_CTRL_START 24
`define CSC_SEED 19:0
`define CSC_CNT_W 20
`define CSC_RST_WIN 20'h0_0010
`define CSC_MON_WIN 64

// ==========================================================
// synchronised source indices
`define CSC_NSRC 20
`define CSC_I_OSC 0
`define CSC_I_PLL 1
`define CSC_I_EXT1 2
`define CSC_I_EXT2 3
`define CSC_I_LF 4
`define CSC_I_HF 5
`define CSC_I_CPU 6
`define CSC_I_RTI 7
`define CSC_I_VA1 8
`define CSC_I_VA2 9
`define CSC_I_HCLK 10
`define CSC_I_PERIPH_CLOCK 11
`define CSC_I_PERIPH_CLOCK_TWO 12
`define CSC_I_PERIPH_CLOCK_FOUR 13
`define CSC_I_TCK 14
`define CSC_I_T1P31 15
`define CSC_I_T2P0 16
`define CSC_I_OSCV 17
`define CSC_I_PLLV 18
`define CSC_I_HFV 19

// ==========================================================
// select codes
`define CSC_E_OSC 5'h00
`define CSC_E_PLL 5'h01
`define CSC_E_EXT1 5'h03
`define CSC_E_LF 5'h04
`define CSC_E_HF 5'h05
`define CSC_E_EXT2 5'h07
`define CSC_E_CPU 5'h08
`define CSC_E_RTI 5'h09
`define CSC_E_VA1 5'h0B
`define CSC_E_VA2 5'h0C
`define CSC_E_HCLK 5'h11
`define CSC_E_PERIPH_CLOCK 5'h12
`define CSC_E_PERIPH_CLOCK_TWO 5'h13
`define CSC_E_PERIPH_CLOCK_FOUR 5'h15
`define CSC_T_OSCV 4'h0
`define CSC_T_PLLV 4'h1
`define CSC_T_RES 4'h2
`define CSC_T_HFV 4'h5
`define CSC_T_LF 4'h8
`define CSC_T_OSCV9 4'h9
`define CSC_T_OSCVA 4'hA
`define CSC_T_OSCVB 4'hB
`define CSC_T_OSCVC 4'hC
`define CSC_T_OSCVF 4'hF
`define CSC_KEY 4'hA
`define CSC_C0_HF 4'h5
`define CSC_C0_TCK 4'hA
`define CSC_C1_PLL 4'h0
`define CSC_C1_LF 4'h2
`define CSC_C1_HF 4'h3
`define CSC_C1_EXT1 4'h5
`define CSC_C1_EXT2 4'h6
`define CSC_C1_PERIPH_CLOCK_MIN 4'h8

`endif

// ---- cscto_pkg.sv ----
// types of the clock supervision and test-out block
// assumes cscto_params.svh is on the include path
`default_nettype none
`include "cscto_params.svh"

package cscto_pkg;

	// ==========================================================
	// types
	typedef logic [`CSC_NSRC-1:0] cscto_src_t;

	typedef enum logic [1:0] {
		CSCTO_IDLE = 2'b00,
		CSCTO_COUNT = 2'b01,
		CSCTO_WINDOW = 2'b10
	} cscto_cmp_st_t;

	typedef struct packed {
		logic [3:0] key;
		logic [3:0] src0;
		logic [3:0] src1;
		logic [`CSC_CNT_W-1:0] seed0;
		logic [`CSC_CNT_W-1:0] seed1;
		logic [`CSC_CNT_W-1:0] win;
	} cscto_cmp_cfg_t;

	typedef struct packed {
		cscto_cmp_st_t st;
		logic [`CSC_CNT_W-1:0] cnt0;
		logic [`CSC_CNT_W-1:0] cnt1;
		logic [`CSC_CNT_W-1:0] wcnt;
		logic done;
		logic err;
	} cscto_cmp_state_t;

	typedef struct packed {
		cscto_src_t s1;
		cscto_src_t s2;
		cscto_src_t s3;
		logic [31:0] test;
		cscto_cmp_cfg_t [1:0] cfg;
		logic [1:0] start;
		logic flag_a;
		logic [1:0] cmp_err;
		logic [11:0] hf_cnt;
		logic [11:0] osc_cnt;
		logic [3:0] pre_cnt;
		logic ext_div;
		logic ext_pin;
		logic tim_pin;
		logic dom_clk;
		logic [31:0] rdata;
	} cscto_state_t;

endpackage
`default_nettype wire

// ---- cscto_comparator.sv ----
// one dual clock comparator: reference counter, test counter, counting window
// assumes edge pulses already synchronised to clk_in, one cycle each
`timescale 1ns/1ns
`default_nettype none
`include "cscto_params.svh"

module cscto_comparator
	import cscto_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic ref_edge_in,
	input wire logic test_edge_in,
	input wire cscto_cmp_cfg_t cfg_in,
	output logic busy_out,
	output logic window_out,
	output logic done_out,
	output logic error_out
);

	cscto_cmp_state_t s;
	cscto_cmp_state_t next_s;

	// true when a decrement brings the counter to zero, or when the counter is already zero
	function automatic logic f_last(input logic [`CSC_CNT_W-1:0] c);
		return c <= `CSC_CNT_W'(1);
	endfunction

	// ==========================================================
	// counting state machine
	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.err = 1'b0;
		unique case (s.st)
			CSCTO_IDLE:
			begin
			end
			CSCTO_COUNT:
			begin
				if (ref_edge_in)
				begin
					next_s.cnt0 = s.cnt0 - `CSC_CNT_W'(1);
					if (f_last(s.cnt0))
					begin
						next_s.st = CSCTO_WINDOW;
						next_s.wcnt = cfg_in.win;
					end
				end
				if (test_edge_in)
				begin
					next_s.cnt1 = s.cnt1 - `CSC_CNT_W'(1);
					if (f_last(s.cnt1))
					begin
						next_s.done = 1'b1;
						next_s.err = 1'b1; // too fast: zero before the window
						next_s.st = CSCTO_IDLE;
					end
				end
			end
			CSCTO_WINDOW:
			begin
				if (test_edge_in && f_last(s.cnt1))
				begin
					next_s.cnt1 = '0;
					next_s.done = 1'b1;
					next_s.st = CSCTO_IDLE;
				end
				else
				begin
					if (test_edge_in)
						next_s.cnt1 = s.cnt1 - `CSC_CNT_W'(1);
					if (ref_edge_in)
					begin
						next_s.wcnt = s.wcnt - `CSC_CNT_W'(1);
						if (f_last(s.wcnt))
						begin
							next_s.err = 1'b1; // window closed, counter 1 not zero
							next_s.st = CSCTO_IDLE;
						end
					end
				end
			end
			default:
			begin
				next_s.st = CSCTO_IDLE;
			end
		endcase
		// both counters load together, start wins over a running count
		if (start_in)
		begin
			next_s.st = CSCTO_COUNT;
			next_s.cnt0 = cfg_in.seed0;
			next_s.cnt1 = cfg_in.seed1;
		end
	end

	// state register
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			s <= '{st: CSCTO_IDLE, default: '0};
		else
			s <= next_s;
	end

	assign busy_out = (s.st != CSCTO_IDLE);
	assign window_out = (s.st == CSCTO_WINDOW);
	assign done_out = s.done;
	assign error_out = s.err;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	AST_CMP_LOAD: assert property (start_in |=> (s.st == CSCTO_COUNT) &&
		(s.cnt0 == $past(cfg_in.seed0)) && (s.cnt1 == $past(cfg_in.seed1)))
		else $error("seeds not loaded together");
	AST_CMP_WIN_OPEN: assert property (!start_in && s.st == CSCTO_COUNT && ref_edge_in &&
		s.cnt0 == `CSC_CNT_W'(1) && !test_edge_in |=> window_out && s.wcnt == $past(cfg_in.win))
		else $error("window did not open at counter 0 zero");
	AST_CMP_DONE_PULSE: assert property (done_out |=> !done_out)
		else $error("done pulse longer than one cycle");
	AST_CMP_LATE_ERR: assert property (!start_in && window_out && ref_edge_in &&
		s.wcnt == `CSC_CNT_W'(1) && !(test_edge_in && s.cnt1 <= `CSC_CNT_W'(1))
		|=> error_out && !busy_out)
		else $error("late test clock not flagged");
	AST_CMP_GOOD: assert property (!start_in && window_out && test_edge_in &&
		s.cnt1 == `CSC_CNT_W'(1) |=> done_out && !error_out)
		else $error("in-window finish flagged as error");
	COV_CMP_GOOD: cover property (window_out ##1 done_out && !error_out);
	COV_CMP_ERR: cover property (window_out ##1 error_out);

endmodule
`default_nettype wire

// ---- cscto_top.sv ----
// clock supervision and test-out: test mux to two pins, oscillator monitor,
// two dual clock comparators, register port
// assumes all clock and status inputs are asynchronous to clk_in (50 MHz) and
// well below half its rate; plain register port, read data one cycle later
//
// Notes on behaviour
// - test mode routes selected signals to the clock pin and timer pin twelve
// - five-bit clock pin select picks sources; other codes are reserved
// - four-bit timer pin select picks valid flags or low oscillator clock
// - low and high internal oscillator clocks; high one is monitor and limp reference
// - oscillator out of window sets fail flag in global status bit 0
// - on failure, oscillator-sourced domains switch to the high internal oscillator
// - oscillator valid only strictly between quarter and four times reference
// - clock pin can drive a prescaled copy of the selected clock
// - comparator counts reference in counter 0, tested clock in counter 1
// - counter 0 reaching zero opens a fixed-width counting window; here its width comes from each comparator's WIN register
// - counter 1 reaching zero gives a one-cycle pulse
// - error when counter 1 does not reach zero inside the window
// - both counters start together; mismatch raises an error for the processor
// - comparator one counter 0: 5 high oscillator, A test clock, else oscillator
// - comparator one counter 1: timer pin 31 unless key A, then source table
// - comparator two counter 0: A test clock, else oscillator
// - comparator two counter 1: timer pin 0 unless key A; 8-F periph clock
`timescale 1ns/1ns
`default_nettype none
`include "cscto_params.svh"

module cscto_top
	import cscto_pkg::*;
#(
	parameter int MON_WIN = `CSC_MON_WIN
)
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rd_data_out,
	input wire logic main_osc_input_in,
	input wire logic pll_clock_in,
	input wire logic ext_clock_in_one_in,
	input wire logic ext_clock_in_two_in,
	input wire logic low_freq_internal_osc_in,
	input wire logic high_freq_internal_osc_in,
	input wire logic cpu_clock_in,
	input wire logic os_timer_base_clock_in,
	input wire logic async_periph_clock_one_in,
	input wire logic async_periph_clock_two_in,
	input wire logic system_bus_clock_in,
	input wire logic periph_clock_in,
	input wire logic periph_clock_two_in,
	input wire logic periph_clock_four_in,
	input wire logic test_clock_in,
	input wire logic timer_one_pin_31_in,
	input wire logic timer_two_pin_0_in,
	input wire logic osc_valid_in,
	input wire logic pll_valid_in,
	input wire logic hf_osc_valid_in,
	output logic ext_clock_out_pin_out,
	output logic timer_pin_twelve_out,
	output logic limp_mode_out,
	output logic domain_clock_out,
	output logic [1:0] comparator_error_out
);

	localparam logic [11:0] MON_LAST = 12'(MON_WIN - 1);
	localparam logic [11:0] MON_LO = 12'(MON_WIN / 4);
	localparam logic [11:0] MON_HI = 12'(4 * MON_WIN);

	// elaboration check on the monitor window
	if (MON_WIN < 8 || (MON_WIN % 4) != 0 || 4 * MON_WIN > 4095)
		$error("MON_WIN must be a multiple of 4 between 8 and 1020");

	cscto_state_t s;
	cscto_state_t next_s;
	cscto_src_t raw;
	cscto_src_t rise;
	logic [1:0] c_ref;
	logic [1:0] c_test;
	logic [1:0] c_busy;
	logic [1:0] c_done;
	logic [1:0] c_err;
	logic fail_set;

	// ==========================================================
	// selection functions
	function automatic logic f_ext(input logic [4:0] sel, input cscto_src_t v);
		case (sel)
			`CSC_E_OSC: return v[`CSC_I_OSC];
			`CSC_E_PLL: return v[`CSC_I_PLL];
			`CSC_E_EXT1: return v[`CSC_I_EXT1];
			`CSC_E_LF: return v[`CSC_I_LF];
			`CSC_E_HF: return v[`CSC_I_HF];
			`CSC_E_EXT2: return v[`CSC_I_EXT2];
			`CSC_E_CPU: return v[`CSC_I_CPU];
			`CSC_E_RTI: return v[`CSC_I_RTI];
			`CSC_E_VA1: return v[`CSC_I_VA1];
			`CSC_E_VA2: return v[`CSC_I_VA2];
			`CSC_E_HCLK: return v[`CSC_I_HCLK];
			`CSC_E_PERIPH_CLOCK: return v[`CSC_I_PERIPH_CLOCK];
			`CSC_E_PERIPH_CLOCK_TWO: return v[`CSC_I_PERIPH_CLOCK_TWO];
			`CSC_E_PERIPH_CLOCK_FOUR: return v[`CSC_I_PERIPH_CLOCK_FOUR];
			default: return 1'b0; // reserved
		endcase
	endfunction

	function automatic logic f_tim(input logic [3:0] sel, input cscto_src_t v);
		case (sel)
			`CSC_T_OSCV, `CSC_T_OSCV9, `CSC_T_OSCVA, `CSC_T_OSCVB, `CSC_T_OSCVC,
			`CSC_T_OSCVF: return v[`CSC_I_OSCV];
			`CSC_T_PLLV: return v[`CSC_I_PLLV];
			`CSC_T_HFV: return v[`CSC_I_HFV];
			`CSC_T_LF: return v[`CSC_I_LF];
			default: return 1'b0; // reserved
		endcase
	endfunction

	// comparator one reference source
	function automatic logic f_c1_ref(input logic [3:0] sel, input cscto_src_t e);
		if (sel == `CSC_C0_HF)
			return e[`CSC_I_HF];
		if (sel == `CSC_C0_TCK)
			return e[`CSC_I_TCK];
		return e[`CSC_I_OSC];
	endfunction

	// comparator one source under
	function automatic logic f_c1_test(input logic [3:0] key, input logic [3:0] sel,
		input cscto_src_t e);
		if (key != `CSC_KEY)
			return e[`CSC_I_T1P31];
		case (sel)
			`CSC_C1_PLL: return e[`CSC_I_PLL];
			`CSC_C1_LF: return e[`CSC_I_LF];
			`CSC_C1_HF: return e[`CSC_I_HF];
			`CSC_C1_EXT1: return e[`CSC_I_EXT1];
			`CSC_C1_EXT2: return e[`CSC_I_EXT2];
			default: return (sel >= `CSC_C1_PERIPH_CLOCK_MIN) ? e[`CSC_I_PERIPH_CLOCK] : 1'b0;
		endcase
	endfunction

	// comparator two sources
	function automatic logic f_c2_ref(input logic [3:0] sel, input cscto_src_t e);
		return (sel == `CSC_C0_TCK) ? e[`CSC_I_TCK] : e[`CSC_I_OSC];
	endfunction

	function automatic logic f_c2_test(input logic [3:0] key, input logic [3:0] sel,
		input cscto_src_t e);
		if (key != `CSC_KEY)
			return e[`CSC_I_T2P0];
		return (sel >= `CSC_C1_PERIPH_CLOCK_MIN) ? e[`CSC_I_PERIPH_CLOCK] : 1'b0;
	endfunction

	// ==========================================================
	// raw source vector and rising edges after the synchroniser
	always_comb
	begin
		raw = '0;
		raw[`CSC_I_OSC] = main_osc_input_in;
		raw[`CSC_I_PLL] = pll_clock_in;
		raw[`CSC_I_EXT1] = ext_clock_in_one_in;
		raw[`CSC_I_EXT2] = ext_clock_in_two_in;
		raw[`CSC_I_LF] = low_freq_internal_osc_in;
		raw[`CSC_I_HF] = high_freq_internal_osc_in;
		raw[`CSC_I_CPU] = cpu_clock_in;
		raw[`CSC_I_RTI] = os_timer_base_clock_in;
		raw[`CSC_I_VA1] = async_periph_clock_one_in;
		raw[`CSC_I_VA2] = async_periph_clock_two_in;
		raw[`CSC_I_HCLK] = system_bus_clock_in;
		raw[`CSC_I_PERIPH_CLOCK] = periph_clock_in;
		raw[`CSC_I_PERIPH_CLOCK_TWO] = periph_clock_two_in;
		raw[`CSC_I_PERIPH_CLOCK_FOUR] = periph_clock_four_in;
		raw[`CSC_I_TCK] = test_clock_in;
		raw[`CSC_I_T1P31] = timer_one_pin_31_in;
		raw[`CSC_I_T2P0] = timer_two_pin_0_in;
		raw[`CSC_I_OSCV] = osc_valid_in;
		raw[`CSC_I_PLLV] = pll_valid_in;
		raw[`CSC_I_HFV] = hf_osc_valid_in;
	end

	assign rise = s.s2 & ~s.s3;

	// comparator source routing
	assign c_ref[0] = f_c1_ref(s.cfg[0].src0, rise);
	assign c_test[0] = f_c1_test(s.cfg[0].key, s.cfg[0].src1, rise);
	assign c_ref[1] = f_c2_ref(s.cfg[1].src0, rise);
	assign c_test[1] = f_c2_test(s.cfg[1].key, s.cfg[1].src1, rise);

	// ==========================================================
	// next state: registers, monitor, test outputs, read data
	always_comb
	begin
		next_s = s;
		fail_set = 1'b0;
		next_s.s1 = raw;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.start = '0;
		next_s.rdata = '0;
		if (wr_in)
		begin
			case (addr_in)
				`CSC_OFF_TEST: next_s.test = wr_data_in & `CSC_TEST_MASK;
				`CSC_OFF_C1_CTRL, `CSC_OFF_C2_CTRL:
				begin
					next_s.cfg[addr_in == `CSC_OFF_C2_CTRL].key = wr_data_in[`CSC_CTRL_KEY];
					next_s.cfg[addr_in == `CSC_OFF_C2_CTRL].src0 = wr_data_in[`CSC_CTRL_SRC0];
					next_s.cfg[addr_in == `CSC_OFF_C2_CTRL].src1 = wr_data_in[`CSC_CTRL_SRC1];
					next_s.start[addr_in == `CSC_OFF_C2_CTRL] = wr_data_in[`CSC_CTRL_START];
				end
				`CSC_OFF_C1_SEED0: next_s.cfg[0].seed0 = wr_data_in[`CSC_SEED];
				`CSC_OFF_C1_SEED1: next_s.cfg[0].seed1 = wr_data_in[`CSC_SEED];
				`CSC_OFF_C1_WIN: next_s.cfg[0].win = wr_data_in[`CSC_SEED];
				`CSC_OFF_C2_SEED0: next_s.cfg[1].seed0 = wr_data_in[`CSC_SEED];
				`CSC_OFF_C2_SEED1: next_s.cfg[1].seed1 = wr_data_in[`CSC_SEED];
				`CSC_OFF_C2_WIN: next_s.cfg[1].win = wr_data_in[`CSC_SEED];
				default:
				begin
				end
			endcase
		end
		// oscillator monitor: oscillator edges over MON_WIN reference edges
		if (rise[`CSC_I_HF] && s.hf_cnt == MON_LAST)
		begin
			fail_set = (s.osc_cnt <= MON_LO); // too slow
			next_s.hf_cnt = '0;
			next_s.osc_cnt = '0;
		end
		else if (rise[`CSC_I_OSC] && s.osc_cnt == MON_HI - 12'h001)
		begin
			fail_set = 1'b1; // too fast
			next_s.hf_cnt = '0;
			next_s.osc_cnt = '0;
		end
		else
		begin
			if (rise[`CSC_I_HF])
				next_s.hf_cnt = s.hf_cnt + 12'h001;
			if (rise[`CSC_I_OSC])
				next_s.osc_cnt = s.osc_cnt + 12'h001;
		end
		// sticky flags, a new event wins over a clear in the same cycle
		next_s.flag_a = fail_set | (s.flag_a &
			~(wr_in && addr_in == `CSC_OFF_STAT && wr_data_in[`CSC_ST_OSC]));
		next_s.cmp_err[0] = c_err[0] | (s.cmp_err[0] &
			~(wr_in && addr_in == `CSC_OFF_STAT && wr_data_in[`CSC_ST_ERR1]));
		next_s.cmp_err[1] = c_err[1] | (s.cmp_err[1] &
			~(wr_in && addr_in == `CSC_OFF_STAT && wr_data_in[`CSC_ST_ERR2]));
		// limp clock replaces the oscillator for its domains
		next_s.dom_clk = s.flag_a ? s.s2[`CSC_I_HF] : s.s2[`CSC_I_OSC];
		// prescaler: divide by twice the field value, zero passes straight
		if (f_ext(s.test[`CSC_TEST_EXT], rise))
		begin
			if (s.pre_cnt + 4'h1 >= s.test[`CSC_TEST_PRE])
			begin
				next_s.pre_cnt = '0;
				next_s.ext_div = ~s.ext_div;
			end
			else
				next_s.pre_cnt = s.pre_cnt + 4'h1;
		end
		// test pins low outside clock test mode
		next_s.ext_pin = 1'b0;
		next_s.tim_pin = 1'b0;
		if (s.test[`CSC_TEST_EN])
		begin
			next_s.ext_pin = (s.test[`CSC_TEST_PRE] == 4'h0) ?
				f_ext(s.test[`CSC_TEST_EXT], s.s2) : s.ext_div;
			next_s.tim_pin = f_tim(s.test[`CSC_TEST_TIM], s.s2);
		end
		// read data, zero for unmapped offsets
		if (rd_in)
		begin
			case (addr_in)
				`CSC_OFF_TEST: next_s.rdata = s.test;
				`CSC_OFF_STAT:
				begin
					next_s.rdata[`CSC_ST_OSC] = s.flag_a;
					next_s.rdata[`CSC_ST_ERR1] = s.cmp_err[0];
					next_s.rdata[`CSC_ST_ERR2] = s.cmp_err[1];
					next_s.rdata[`CSC_ST_LIMP] = s.flag_a;
					next_s.rdata[`CSC_ST_BUSY1] = c_busy[0];
					next_s.rdata[`CSC_ST_BUSY2] = c_busy[1];
				end
				`CSC_OFF_C1_CTRL, `CSC_OFF_C2_CTRL:
				begin
					next_s.rdata[`CSC_CTRL_KEY] = s.cfg[addr_in == `CSC_OFF_C2_CTRL].key;
					next_s.rdata[`CSC_CTRL_SRC0] = s.cfg[addr_in == `CSC_OFF_C2_CTRL].src0;
					next_s.rdata[`CSC_CTRL_SRC1] = s.cfg[addr_in == `CSC_OFF_C2_CTRL].src1;
				end
				`CSC_OFF_C1_SEED0: next_s.rdata[`CSC_SEED] = s.cfg[0].seed0;
				`CSC_OFF_C1_SEED1: next_s.rdata[`CSC_SEED] = s.cfg[0].seed1;
				`CSC_OFF_C1_WIN: next_s.rdata[`CSC_SEED] = s.cfg[0].win;
				`CSC_OFF_C2_SEED0: next_s.rdata[`CSC_SEED] = s.cfg[1].seed0;
				`CSC_OFF_C2_SEED1: next_s.rdata[`CSC_SEED] = s.cfg[1].seed1;
				`CSC_OFF_C2_WIN: next_s.rdata[`CSC_SEED] = s.cfg[1].win;
				default: next_s.rdata = '0;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			s <= '0;
			s.cfg[0].win <= `CSC_RST_WIN;
			s.cfg[1].win <= `CSC_RST_WIN;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// the two comparators
	for (genvar g = 0; g < 2; g++)
	begin : g_cmp
		cscto_comparator u_cmp (
			.clk_in(clk_in),
			.resetn_in(resetn_in),
			.start_in(s.start[g]),
			.ref_edge_in(c_ref[g]),
			.test_edge_in(c_test[g]),
			.cfg_in(s.cfg[g]),
			.busy_out(c_busy[g]),
			.window_out(),
			.done_out(c_done[g]),
			.error_out(c_err[g])
		);
	end

	// outputs
	assign rd_data_out = s.rdata;
	assign ext_clock_out_pin_out = s.ext_pin;
	assign timer_pin_twelve_out = s.tim_pin;
	assign limp_mode_out = s.flag_a;
	assign domain_clock_out = s.dom_clk;
	assign comparator_error_out = s.cmp_err;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	AST_EXT_OFF: assert property (!s.test[`CSC_TEST_EN] |=> !ext_clock_out_pin_out)
		else $error("clock pin driven outside test mode");
	AST_EXT_HF: assert property (s.test[`CSC_TEST_EN] && s.test[`CSC_TEST_EXT] == `CSC_E_HF &&
		s.test[`CSC_TEST_PRE] == 4'h0 |=> ext_clock_out_pin_out == $past(s.s2[`CSC_I_HF]))
		else $error("clock pin does not follow high oscillator");
	AST_TIM_PLLV: assert property (s.test[`CSC_TEST_EN] && s.test[`CSC_TEST_TIM] == `CSC_T_PLLV
		|=> timer_pin_twelve_out == $past(s.s2[`CSC_I_PLLV]))
		else $error("timer pin does not show pll valid");
	AST_TIM_RES: assert property (s.test[`CSC_TEST_TIM] == `CSC_T_RES |=> !timer_pin_twelve_out)
		else $error("reserved timer select not low");
	AST_FAIL_SET: assert property (fail_set |=> s.flag_a && limp_mode_out)
		else $error("fail flag not set");
	AST_FAIL_SLOW: assert property (rise[`CSC_I_HF] && s.hf_cnt == MON_LAST &&
		s.osc_cnt <= MON_LO |=> s.flag_a)
		else $error("slow oscillator not flagged");
	AST_FAIL_KEEP: assert property (s.flag_a && !(wr_in && addr_in == `CSC_OFF_STAT)
		|=> s.flag_a)
		else $error("fail flag lost without a clear");
	AST_LIMP: assert property (s.flag_a |=> domain_clock_out == $past(s.s2[`CSC_I_HF]))
		else $error("limp clock not selected");
	AST_ERR_KEEP: assert property (c_err[0] |=> comparator_error_out[0])
		else $error("comparator error not held");
	AST_C2_TCK: assert property (s.cfg[1].src0 == `CSC_C0_TCK |-> c_ref[1] == rise[`CSC_I_TCK])
		else $error("comparator two reference not test clock");
	COV_FAIL: cover property (fail_set ##1 limp_mode_out);
	COV_DONE: cover property (c_done[0] && !c_err[0]);
	COV_ERR2: cover property (c_err[1]);

endmodule
`default_nettype wire

// ---- cscto_osc_model.sv ----
// partner: main oscillator and high internal oscillator sources
// assumes 1 ns units; run_in low stops the main oscillator
`timescale 1ns/1ns
`default_nettype none
module cscto_osc_model
(
	input wire logic run_in,
	output logic osc_out,
	output logic hf_out
);
	// high oscillator runs free as the reference
	initial
	begin
		hf_out = 1'b0;
		forever #80 hf_out = ~hf_out;
	end
	// main oscillator, within the valid window, held low when stopped
	initial
	begin
		osc_out = 1'b0;
		forever #60 osc_out = run_in & ~osc_out;
	end
endmodule
`default_nettype wire

// ---- cscto_top_bench.sv ----
// testbench of the clock supervision block: register port, pins, monitor
// assumes the design files and the oscillator model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "cscto_params.svh"
module cscto_top_bench;
	import cscto_pkg::*;
	localparam logic [4:0] EC [12] = '{`CSC_E_PLL, `CSC_E_EXT1, `CSC_E_LF, `CSC_E_EXT2,
		`CSC_E_CPU, `CSC_E_RTI, `CSC_E_VA1, `CSC_E_VA2, `CSC_E_HCLK, `CSC_E_PERIPH_CLOCK,
		`CSC_E_PERIPH_CLOCK_TWO, `CSC_E_PERIPH_CLOCK_FOUR};
	localparam int EI [12] = '{1, 2, 4, 3, 6, 7, 8, 9, 10, 11, 12, 13};
	localparam logic [3:0] TC [9] = '{`CSC_T_PLLV, `CSC_T_HFV, `CSC_T_LF, `CSC_T_OSCV,
		`CSC_T_OSCV9, `CSC_T_OSCVA, `CSC_T_OSCVB, `CSC_T_OSCVC, `CSC_T_OSCVF};
	localparam int TI [9] = '{18, 19, 4, 17, 17, 17, 17, 17, 17};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] a = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic w = 1'b0;
	logic r = 1'b0;
	logic run = 1'b1;
	logic seen = 1'b0;
	logic [19:0] v = 20'h0_0000;
	logic [31:0] rdd;
	logic osc, hf, ext, tim, limp, dom;
	logic e0 = 1'b0;
	int k = 0;
	logic [1:0] cerr;
	logic [31:0] q[$];
	int fail_count = 0;
	int n_compared = 0;
	cscto_osc_model i_osc (.run_in(run), .osc_out(osc), .hf_out(hf));
	cscto_top #(.MON_WIN(8)) i_dut (.clk_in(clk), .resetn_in(resetn), .addr_in(a),
		.wr_data_in(wd), .wr_in(w), .rd_in(r), .rd_data_out(rdd),
		.main_osc_input_in(osc), .pll_clock_in(v[1]), .ext_clock_in_one_in(v[2]),
		.ext_clock_in_two_in(v[3]), .low_freq_internal_osc_in(v[4]),
		.high_freq_internal_osc_in(hf), .cpu_clock_in(v[6]),
		.os_timer_base_clock_in(v[7]), .async_periph_clock_one_in(v[8]),
		.async_periph_clock_two_in(v[9]), .system_bus_clock_in(v[10]),
		.periph_clock_in(v[11]), .periph_clock_two_in(v[12]),
		.periph_clock_four_in(v[13]), .test_clock_in(v[14]),
		.timer_one_pin_31_in(v[15]), .timer_two_pin_0_in(v[16]), .osc_valid_in(v[17]),
		.pll_valid_in(v[18]), .hf_osc_valid_in(v[19]), .ext_clock_out_pin_out(ext),
		.timer_pin_twelve_out(tim), .limp_mode_out(limp), .domain_clock_out(dom),
		.comparator_error_out(cerr));
	// clock generation
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic wrt(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		w <= 1'b1;
		@(posedge clk);
		w <= 1'b0;
	endtask
	task automatic rdt(input logic [7:0] ad, input logic [31:0] e);
		@(posedge clk);
		a <= ad;
		r <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		r <= 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// read monitor: data stands in the cycle after the strobe
	always @(negedge clk)
	begin
		if (seen)
			chk("rd_data", q.pop_front(), rdd);
		seen <= r;
	end
	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
	// main sequence
	initial
	begin
		void'($urandom(92));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rdt(`CSC_OFF_C1_WIN, 32'h0000_0010);
		rdt(8'h30, 32'h0000_0000);
		wrt(`CSC_OFF_TEST, 32'hFFFF_FFFF);
		rdt(`CSC_OFF_TEST, `CSC_TEST_MASK);
		for (int i = 0; i < 12; i++)
		begin
			wrt(`CSC_OFF_TEST, 32'h0100_0000 | 32'(EC[i]));
			v <= 20'($urandom);
			repeat (6) @(posedge clk);
			chk("ext_pin", 32'(v[EI[i]]), 32'(ext));
			v <= ~v;
			repeat (6) @(posedge clk);
			chk("ext_pin", 32'(v[EI[i]]), 32'(ext));
		end
		for (int i = 0; i < 9; i++)
		begin
			wrt(`CSC_OFF_TEST, 32'h0100_0000 | {20'h0_0000, TC[i], 8'h00});
			v <= 20'($urandom);
			repeat (6) @(posedge clk);
			chk("tim_pin", 32'(v[TI[i]]), 32'(tim));
			v <= ~v;
			repeat (6) @(posedge clk);
			chk("tim_pin", 32'(v[TI[i]]), 32'(tim));
		end
		wrt(`CSC_OFF_TEST, 32'h0100_0202);
		v <= 20'hF_FFFF;
		repeat (6) @(posedge clk);
		chk("ext_pin", 32'h0000_0000, 32'(ext));
		chk("tim_pin", 32'h0000_0000, 32'(tim));
		v <= 20'h0_0000;
		rdt(`CSC_OFF_STAT, 32'h0000_0000);
		// prescale field 2, divide by 4: eight source rises give four pin changes
		wrt(`CSC_OFF_TEST, 32'h0102_0004);
		repeat (2) @(posedge clk);
		e0 = ext;
		k = 0;
		for (int j = 0; j < 72; j++)
		begin
			v[4] <= (j < 64) && j[2];
			@(negedge clk);
			k += int'(ext != e0);
			e0 = ext;
			@(posedge clk);
		end
		chk("ext_div", 32'h0000_0004, 32'(k));
		run <= 1'b0;
		repeat (300) @(posedge clk);
		chk("limp", 32'h0000_0001, 32'(limp));
		// stopped oscillator: domain clock must follow the high oscillator
		@(negedge clk);
		e0 = dom;
		k = 0;
		repeat (40)
		begin
			@(negedge clk);
			k += int'(dom != e0);
			e0 = dom;
		end
		chk("dom_clk", 32'h0000_000A, 32'(k));
		rdt(`CSC_OFF_STAT, 32'h0000_0009);
		run <= 1'b1;
		repeat (300) @(posedge clk);
		chk("limp", 32'h0000_0001, 32'(limp));
		wrt(`CSC_OFF_STAT, 32'h0000_0001);
		rdt(`CSC_OFF_STAT, 32'h0000_0000);
		wrt(`CSC_OFF_C1_SEED0, 32'h0000_0002);
		wrt(`CSC_OFF_C1_SEED1, 32'h0000_0003);
		wrt(`CSC_OFF_C1_WIN, 32'h0000_0004);
		wrt(`CSC_OFF_C1_CTRL, 32'h0103_050A);
		rdt(`CSC_OFF_STAT, 32'h0000_0100);
		repeat (200) @(posedge clk);
		rdt(`CSC_OFF_STAT, 32'h0000_0000);
		wrt(`CSC_OFF_C2_SEED0, 32'h0000_0002);
		wrt(`CSC_OFF_C2_SEED1, 32'h0000_0003);
		wrt(`CSC_OFF_C2_WIN, 32'h0000_0004);
		wrt(`CSC_OFF_C2_CTRL, 32'h0100_0000);
		repeat (200) @(posedge clk);
		chk("cmp_err", 32'h0000_0002, 32'(cerr));
		rdt(`CSC_OFF_STAT, 32'h0000_0004);
		wrt(`CSC_OFF_STAT, 32'h0000_0004);
		rdt(`CSC_OFF_STAT, 32'h0000_0000);
		// comparator two, key set: test clock reference, periph clock under test
		wrt(`CSC_OFF_C2_CTRL, 32'h0108_0A0A);
		repeat (20)
		begin
			v <= ~v;
			repeat (12) @(posedge clk);
		end
		rdt(`CSC_OFF_STAT, 32'h0000_0000);
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
`default_nettype wire
